// ==== design/pdwc_pkg.sv ====
// Package of constants for the power-down and wake control block.
package pdwc_pkg;
   // APB register byte offsets.
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
   localparam logic [7:0] SRC_EN_OFS = 8'h10;
   // Status bit positions.
   localparam int PD_BIT = 3;
   localparam int TO_BIT = 4;
   // Control register fields.
   localparam int CTRL_GIE_BIT = 0;
   localparam int CTRL_WDT_EN_BIT = 1;
   localparam int CTRL_T1_ASYNC_BIT = 2;
   // Wake source indices.
   localparam int SRC_EXT_INT = 0;
   localparam int SRC_PORT_CHG = 1;
   localparam int SRC_T1_OVF = 2;
   localparam int SRC_SSP_SS = 3;
   localparam int SRC_SSP_XFER = 4;
   localparam int SRC_CAPTURE = 5;
   localparam int SRC_PSP = 6;
   localparam int SRC_USART_SYNC = 7;
   localparam int NUM_SRC = 8;
   // Interrupt event bits.
   localparam int EV_SLEEP = 0;
   localparam int EV_WAKE_INT = 1;
   localparam int EV_WAKE_WDT = 2;
   localparam int NUM_EV = 3;
   // Reset values and the vector address.
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [7:0] SRC_EN_RST = 8'h00;
   localparam logic [15:0] VECTOR_ADDR = 16'h0004;
   // Oscillator restart time before execution resumes.
   localparam int OSC_RESTART_NS = 200;
   localparam int CLK_PERIOD_NS = 25;
   localparam int OSC_RESTART_CYC = (OSC_RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic [1:0] {
      PDWC_RUN = 2'b00,
      PDWC_SLEEP = 2'b01,
      PDWC_RESTART = 2'b11
   } pdwc_state_t;
endpackage : pdwc_pkg

// ==== design/pdwc_sync.sv ====
// Two-flop synchroniser bank for asynchronous wake inputs.
module pdwc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;
endmodule : pdwc_sync

// ==== design/pdwc_top.sv ====
// Power-down and wake control with APB registers and an interrupt.
//
// The register addresses and the APB register port were left to the implementer.
module pdwc_top #(
   parameter int RESTART_CYC = pdwc_pkg::OSC_RESTART_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleep_exec,
   input wire logic watchdog_clear_instruction,
   input wire logic watchdog_timeout,
   input wire logic [pdwc_pkg::NUM_SRC-1:0] int_flags,
   input wire logic [7:0] port_out_in,
   input wire logic [7:0] port_oe_in,
   output logic [7:0] port_out,
   output logic [7:0] port_oe,
   output logic osc_drive_en,
   output logic qclk_en,
   output logic core_run,
   output logic watchdog_clr,
   output logic resume_pulse,
   output logic vector_req,
   output logic [15:0] vector_addr,
   output logic irq
);
   if (RESTART_CYC < 1 || RESTART_CYC > 255) begin : g_restart_range
      $error("RESTART_CYC out of range");
   end
   localparam int RESUME_LAT = RESTART_CYC + 1;

   pdwc_pkg::pdwc_state_t state_ff, nxt_state;
   logic [2:0] ctrl_ff;
   logic [7:0] src_en_ff;
   logic [2:0] irq_stat_ff;
   logic [2:0] irq_mask_ff;
   logic pd_ff, to_ff;
   logic [7:0] cnt_ff;
   logic wake_int_ff, gie_at_wake_ff;
   logic [7:0] port_out_ff, port_oe_ff;
   logic osc_ff, qclk_ff, run_ff, wclr_ff, resume_ff, vec_ff, irq_ff;
   logic [31:0] prdata_ff;
   logic pready_ff, pslverr_ff;
   logic [pdwc_pkg::NUM_SRC-1:0] flags_sync;

   pdwc_sync #(.WIDTH(pdwc_pkg::NUM_SRC)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(int_flags),
      .sync_out(flags_sync)
   );
   logic wdt_to_m_ff, wdt_to_s_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_to_m_ff <= 1'b0;
         wdt_to_s_ff <= 1'b0;
      end else begin
         wdt_to_m_ff <= watchdog_timeout;
         wdt_to_s_ff <= wdt_to_m_ff;
      end
   end

   // Bus decode.
   wire acc = psel && penable && !pready_ff;
   wire wr = acc && pwrite;
   wire sel_ctrl = (paddr == pdwc_pkg::CTRL_OFS);
   wire sel_stat = (paddr == pdwc_pkg::STAT_OFS);
   wire sel_istat = (paddr == pdwc_pkg::IRQ_STAT_OFS);
   wire sel_imask = (paddr == pdwc_pkg::IRQ_MASK_OFS);
   wire sel_src = (paddr == pdwc_pkg::SRC_EN_OFS);
   wire mapped = sel_ctrl || sel_stat || sel_istat || sel_imask || sel_src;
   wire global_interrupt_enable = ctrl_ff[pdwc_pkg::CTRL_GIE_BIT];
   wire wdt_en = ctrl_ff[pdwc_pkg::CTRL_WDT_EN_BIT];
   wire t1_async = ctrl_ff[pdwc_pkg::CTRL_T1_ASYNC_BIT];

   wire [pdwc_pkg::NUM_SRC-1:0] qual_mask = {{(pdwc_pkg::NUM_SRC-3){1'b1}}, t1_async, 2'b11};
   wire [pdwc_pkg::NUM_SRC-1:0] wake_src = flags_sync & src_en_ff & qual_mask;
   wire int_pending = |wake_src;
   wire wdt_wake = wdt_en && wdt_to_s_ff;
   wire in_run = (state_ff == pdwc_pkg::PDWC_RUN);
   // With the global enable clear, a pending flag would wake at once, so entry is skipped.
   // Sleep as no-op.
   wire sleep_nop = !global_interrupt_enable && int_pending;
   wire sleep_go = in_run && sleep_exec && !sleep_nop;
   wire in_sleep = (state_ff == pdwc_pkg::PDWC_SLEEP);
   wire wake_now = in_sleep && (int_pending || wdt_wake);
   wire restart_done = (state_ff == pdwc_pkg::PDWC_RESTART) && (cnt_ff == 8'h01);
   wire [2:0] events = {wake_now && !int_pending, wake_now && int_pending, sleep_go};

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         pdwc_pkg::PDWC_RUN: begin
            if (sleep_go) begin
               nxt_state = pdwc_pkg::PDWC_SLEEP;
            end
         end
         pdwc_pkg::PDWC_SLEEP: begin
            if (wake_now) begin
               nxt_state = pdwc_pkg::PDWC_RESTART;
            end
         end
         pdwc_pkg::PDWC_RESTART: begin
            if (restart_done) begin
               nxt_state = pdwc_pkg::PDWC_RUN;
            end
         end
         default: nxt_state = pdwc_pkg::PDWC_RUN;
      endcase
   end

   // Master-clear is presetn: full reset; wakes below never reset state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= pdwc_pkg::PDWC_RUN;
         cnt_ff <= 8'h00;
         wake_int_ff <= 1'b0;
         gie_at_wake_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (wake_now) begin
            cnt_ff <= 8'(RESTART_CYC);
            wake_int_ff <= int_pending;
            gie_at_wake_ff <= global_interrupt_enable;
         end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
         end
      end
   end

   // Flag values: power-down flag set at power-up.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pd_ff <= 1'b1;
         to_ff <= 1'b1;
      end else if (sleep_go) begin
         pd_ff <= 1'b0;
         to_ff <= 1'b1;
      end else if (wake_now && !int_pending) begin
         to_ff <= 1'b0;
      end else if (in_run && watchdog_clear_instruction) begin
         pd_ff <= 1'b1;
         to_ff <= 1'b1;
      end
   end

   // Outputs from flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_out_ff <= 8'h00;
         port_oe_ff <= 8'h00;
         osc_ff <= 1'b1;
         qclk_ff <= 1'b1;
         run_ff <= 1'b1;
         wclr_ff <= 1'b0;
         resume_ff <= 1'b0;
         vec_ff <= 1'b0;
      end else begin
         if (nxt_state == pdwc_pkg::PDWC_RUN) begin
            port_out_ff <= port_out_in;
            port_oe_ff <= port_oe_in;
         end
         osc_ff <= (nxt_state != pdwc_pkg::PDWC_SLEEP);
         qclk_ff <= (nxt_state == pdwc_pkg::PDWC_RUN);
         run_ff <= (nxt_state == pdwc_pkg::PDWC_RUN);
         wclr_ff <= sleep_go || (in_run && watchdog_clear_instruction);
         // Resume after sleep; prefetched instruction runs first.
         resume_ff <= restart_done;
         // Vector request in the same cycle as the resume pulse.
         vec_ff <= restart_done && wake_int_ff && gie_at_wake_ff;
      end
   end

   // Register file and interrupt status.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= pdwc_pkg::CTRL_RST;
         src_en_ff <= pdwc_pkg::SRC_EN_RST;
         irq_mask_ff <= 3'h0;
         irq_stat_ff <= 3'h0;
         irq_ff <= 1'b0;
      end else begin
         if (wr && sel_ctrl) begin
            ctrl_ff <= pwdata[2:0];
         end
         if (wr && sel_src) begin
            src_en_ff <= pwdata[7:0];
         end
         if (wr && sel_imask) begin
            irq_mask_ff <= pwdata[2:0];
         end
         // Set wins over a simultaneous write-one clear.
         irq_stat_ff <= (irq_stat_ff & ~((wr && sel_istat) ? pwdata[2:0] : 3'h0)) | events;
         irq_ff <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   wire [31:0] rd_mux = sel_ctrl ? {29'h0, ctrl_ff} :
                        sel_stat ? {27'h0, to_ff, pd_ff, 1'b0, state_ff} :
                        sel_istat ? {29'h0, irq_stat_ff} :
                        sel_imask ? {29'h0, irq_mask_ff} :
                        sel_src ? {24'h0, src_en_ff} : 32'h0;

   // One wait state: pready rises in the second access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0;
      end else begin
         pready_ff <= acc;
         pslverr_ff <= acc && !mapped;
         prdata_ff <= (acc && !pwrite) ? rd_mux : 32'h0;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign port_out = port_out_ff;
   assign port_oe = port_oe_ff;
   assign osc_drive_en = osc_ff;
   assign qclk_en = qclk_ff;
   assign core_run = run_ff;
   assign watchdog_clr = wclr_ff;
   assign resume_pulse = resume_ff;
   assign vector_req = vec_ff;
   assign vector_addr = pdwc_pkg::VECTOR_ADDR;
   assign irq = irq_ff;

   AST_SLEEP_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
      sleep_go |=> (state_ff == pdwc_pkg::PDWC_SLEEP) ##1 !osc_drive_en)
      else $error("sleep not entered");
   AST_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
      sleep_go |=> !pd_ff && to_ff && watchdog_clr)
      else $error("entry flags wrong");
   AST_PORT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      in_sleep && $past(in_sleep) |-> $stable(port_out) && $stable(port_oe))
      else $error("ports moved in sleep");
   AST_NOP: assert property (@(posedge pclk) disable iff (!presetn)
      (in_run && sleep_exec && sleep_nop) |=> in_run && $stable(pd_ff))
      else $error("nop sleep changed state");
   AST_WDT_TO: assert property (@(posedge pclk) disable iff (!presetn)
      (wake_now && !int_pending) |=> !to_ff)
      else $error("time-out flag not cleared");
   AST_TIMER_QUAL: assert property (@(posedge pclk) disable iff (!presetn)
      !t1_async |-> !wake_src[pdwc_pkg::SRC_T1_OVF])
      else $error("timer wake while synchronous");
   AST_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
      resume_pulse |-> osc_drive_en && core_run && qclk_en)
      else $error("resume before clocks");
   AST_VECTOR: assert property (@(posedge pclk) disable iff (!presetn)
      vector_req |-> resume_pulse && gie_at_wake_ff)
      else $error("bad vector");
   AST_NO_VEC: assert property (@(posedge pclk) disable iff (!presetn)
      (restart_done && !gie_at_wake_ff) |=> !vector_req)
      else $error("vector with gie clear");
   AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
      (in_sleep && int_pending) |=> state_ff == pdwc_pkg::PDWC_RESTART)
      else $error("missed wake");

   AST_WDT_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
      (in_sleep && wdt_wake) |=> state_ff == pdwc_pkg::PDWC_RESTART)
      else $error("missed watchdog wake");
   AST_WAKE_KEEPS: assert property (@(posedge pclk) disable iff (!presetn)
      (wake_now && !wr) |=> $stable(ctrl_ff) && $stable(src_en_ff))
      else $error("wake disturbed registers");
   AST_OSC_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      in_sleep |-> !osc_drive_en)
      else $error("oscillator on in sleep");
   AST_QCLK_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      in_sleep |-> !qclk_en && !core_run)
      else $error("quarter clocks on in sleep");
   AST_EN_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      (in_sleep && !wdt_wake && !(|(flags_sync & src_en_ff))) |=> in_sleep)
      else $error("wake without enabled source");
   AST_GIE_FREE: assert property (@(posedge pclk) disable iff (!presetn)
      (in_sleep && int_pending && !global_interrupt_enable) |=> state_ff == pdwc_pkg::PDWC_RESTART)
      else $error("wake blocked by global enable");
   AST_RESUME_ONE: assert property (@(posedge pclk) disable iff (!presetn)
      resume_pulse |=> !resume_pulse)
      else $error("resume pulse too long");
   AST_RESTART_LEN: assert property (@(posedge pclk) disable iff (!presetn)
      wake_now |-> ##[RESUME_LAT:RESUME_LAT] resume_pulse)
      else $error("restart time wrong");
   AST_NOP_WCLR: assert property (@(posedge pclk) disable iff (!presetn)
      (in_run && sleep_exec && sleep_nop && !watchdog_clear_instruction) |=> !watchdog_clr
      && $stable(to_ff))
      else $error("no-op sleep touched watchdog");
   AST_LATE_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
      (in_sleep && int_pending) |=> !pd_ff && to_ff)
      else $error("entry flags lost on wake");
   AST_PD_RISE: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(pd_ff) |-> $past(watchdog_clear_instruction))
      else $error("power-down flag set without clear");
endmodule : pdwc_top

// ==== dv/pdwc_core_model.sv ====
// Behavioural core, watchdog and interrupt flag sources facing the block.
module pdwc_core_model #(
   parameter int WDT_CYC = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic go_sleep,
   input wire logic [7:0] set_flags,
   input wire logic clr_flags,
   input wire logic wdt_en,
   input wire logic watchdog_clr,
   output logic sleep_exec,
   output logic watchdog_timeout,
   output logic [7:0] int_flags,
   output logic [7:0] port_out_in,
   output logic [7:0] port_oe_in
);
   logic sleep_ff;
   logic [7:0] flags_ff;
   logic [7:0] wdt_cnt_ff;
   logic [7:0] port_cnt_ff;
   assign sleep_exec = sleep_ff;
   assign int_flags = flags_ff;
   // watchdog time-out source
   // The pulse lasts four cycles so that the two-flop synchroniser cannot miss it.
   assign watchdog_timeout = wdt_en && (wdt_cnt_ff >= 8'(WDT_CYC));
   // Ports keep moving, so a frozen copy differs from the live value except when the 8-bit count wraps every 256 cycles.
   assign port_out_in = port_cnt_ff;
   assign port_oe_in = ~port_cnt_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_ff <= 1'h0;
         flags_ff <= 8'h00;
         wdt_cnt_ff <= 8'h00;
         port_cnt_ff <= 8'h00;
      end else begin
         sleep_ff <= go_sleep;
         flags_ff <= clr_flags ? 8'h00 : (flags_ff | set_flags);
         port_cnt_ff <= port_cnt_ff + 8'h01;
         if (watchdog_clr || !wdt_en || wdt_cnt_ff == 8'(WDT_CYC + 3)) begin
            wdt_cnt_ff <= 8'h00;
         end else begin
            wdt_cnt_ff <= wdt_cnt_ff + 8'h01;
         end
      end
   end
endmodule : pdwc_core_model

// ==== dv/tb_pdwc_top.sv ====
// Self-checking bench for the power-down and wake control block.
module tb_pdwc_top;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {logic [2:0] ctrl; logic [7:0] en; logic [7:0] flag; logic wake;} pdwc_row_t;
   pdwc_row_t rows [10] = '{'{3'h0, 8'h01, 8'h01, 1'h1}, '{3'h1, 8'h02, 8'h02, 1'h1},
      '{3'h4, 8'h04, 8'h04, 1'h1}, '{3'h0, 8'h04, 8'h04, 1'h0}, '{3'h0, 8'h08, 8'h08, 1'h1},
      '{3'h0, 8'h10, 8'h10, 1'h1}, '{3'h0, 8'h20, 8'h20, 1'h1}, '{3'h0, 8'h40, 8'h40, 1'h1},
      '{3'h0, 8'h80, 8'h80, 1'h1}, '{3'h0, 8'hfe, 8'h01, 1'h0}};
   logic pclk = 1'h0;
   logic presetn, psel, penable, pwrite, pready, pslverr, sleep_exec, wclr_ins, wdt_to;
   logic [7:0] paddr, int_flags, port_out_in, port_oe_in, port_out, port_oe, set_flags;
   logic [31:0] pwdata, prdata, rdat;
   logic osc_drive_en, qclk_en, core_run, watchdog_clr, resume_pulse, vector_req, irq;
   logic go_sleep, clr_flags, wdt_en, got, vec, irq_a, rerr;
   logic [15:0] vector_addr, snap;
   int errors = 0;
   int compares = 0;
   int wclr_n = 0;
   int n0;
   pdwc_top u_pdwc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleep_exec(sleep_exec), .watchdog_clear_instruction(wclr_ins),
      .watchdog_timeout(wdt_to), .int_flags(int_flags), .port_out_in(port_out_in),
      .port_oe_in(port_oe_in), .port_out(port_out), .port_oe(port_oe),
      .osc_drive_en(osc_drive_en), .qclk_en(qclk_en), .core_run(core_run),
      .watchdog_clr(watchdog_clr), .resume_pulse(resume_pulse), .vector_req(vector_req),
      .vector_addr(vector_addr), .irq(irq));
   pdwc_core_model #(.WDT_CYC(20)) u_pdwc_core_model (.pclk(pclk), .presetn(presetn),
      .go_sleep(go_sleep), .set_flags(set_flags), .clr_flags(clr_flags), .wdt_en(wdt_en),
      .watchdog_clr(watchdog_clr), .sleep_exec(sleep_exec), .watchdog_timeout(wdt_to),
      .int_flags(int_flags), .port_out_in(port_out_in), .port_oe_in(port_oe_in));
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (watchdog_clr === 1'h1) wclr_n++;
   end
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      chk("apb_ready", pready, 32'h1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask : apb
   task wait_resume(input int lim);
      got = 1'h0;
      vec = 1'h0;
      for (int n = 0; n < lim && got === 1'h0; n++) begin
         @(posedge pclk);
         if (resume_pulse === 1'h1) begin
            got = 1'h1;
            vec = vector_req;
         end
      end
   endtask : wait_resume
   task pulse_sleep(input logic [7:0] f);
      go_sleep <= 1'h1;
      set_flags <= f;
      @(posedge pclk);
      go_sleep <= 1'h0;
      set_flags <= 8'h00;
   endtask : pulse_sleep
   task tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish
   initial begin
      #(25 * 20000);
      errors++;
      tally_and_finish();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, go_sleep, wclr_ins} = '0;
      {set_flags, clr_flags, wdt_en} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      apb(1'h0, pdwc_pkg::CTRL_OFS, 32'h0);
      chk("ctrl_rst", rdat, 32'h0);
      apb(1'h0, pdwc_pkg::STAT_OFS, 32'h0);
      chk("stat_rst", rdat[4:3], 2'h3);
      apb(1'h0, 8'h14, 32'h0);
      chk("unmapped_err", rerr, 1'h1);
      chk("unmapped_data", rdat, 32'h0);
      foreach (rows[i]) begin
         apb(1'h1, pdwc_pkg::CTRL_OFS, 32'(rows[i].ctrl));
         apb(1'h1, pdwc_pkg::SRC_EN_OFS, 32'(rows[i].en));
         pulse_sleep(8'h00);
         repeat (6) @(posedge pclk);
         chk("clocks_off", {osc_drive_en, qclk_en, core_run}, 3'h0);
         snap = {port_oe, port_out};
         apb(1'h0, pdwc_pkg::STAT_OFS, 32'h0);
         chk("stat_sleep", rdat[4:3], 2'h2);
         chk("ports", {port_oe, port_out}, snap);
         set_flags <= rows[i].flag;
         @(posedge pclk);
         set_flags <= 8'h00;
         wait_resume(40);
         chk("wake", got, rows[i].wake);
         chk("vector", vec, rows[i].wake & rows[i].ctrl[0]);
         chk("clocks_on", {osc_drive_en, qclk_en}, {2{rows[i].wake}});
         // Master-clear stays high except for this reset wake.
         if (got !== 1'h1) begin
            presetn <= 1'h0;
            repeat (2) @(posedge pclk);
            presetn <= 1'h1;
            @(posedge pclk);
         end
         apb(1'h0, pdwc_pkg::STAT_OFS, 32'h0);
         chk("stat_after", rdat[3], !rows[i].wake);
         clr_flags <= 1'h1;
         @(posedge pclk);
         clr_flags <= 1'h0;
      end
      chk("vec_addr", vector_addr, 16'h0004);
      apb(1'h1, pdwc_pkg::SRC_EN_OFS, 32'h1);
      set_flags <= 8'h01;
      @(posedge pclk);
      set_flags <= 8'h00;
      repeat (4) @(posedge pclk);
      n0 = wclr_n;
      pulse_sleep(8'h00);
      repeat (8) @(posedge pclk);
      apb(1'h0, pdwc_pkg::STAT_OFS, 32'h0);
      chk("noop_sleep", {core_run, 8'(wclr_n - n0), rdat[4:3]}, {1'h1, 8'h0, 2'h3});
      clr_flags <= 1'h1;
      @(posedge pclk);
      clr_flags <= 1'h0;
      // The cleared flag must leave the synchroniser before the next sleep.
      repeat (3) @(posedge pclk);
      n0 = wclr_n;
      pulse_sleep(8'h01);
      wait_resume(40);
      apb(1'h0, pdwc_pkg::STAT_OFS, 32'h0);
      chk("late_flag", {got, 8'(wclr_n - n0), rdat[4:3]}, {1'h1, 8'h1, 2'h2});
      clr_flags <= 1'h1;
      apb(1'h1, pdwc_pkg::CTRL_OFS, 32'h2);
      clr_flags <= 1'h0;
      wdt_en <= 1'h1;
      pulse_sleep(8'h00);
      wait_resume(80);
      wdt_en <= 1'h0;
      apb(1'h0, pdwc_pkg::STAT_OFS, 32'h0);
      chk("wdt_wake", {got, rdat[4:3]}, {1'h1, 2'h0});
      apb(1'h0, pdwc_pkg::IRQ_STAT_OFS, 32'h0);
      chk("wdt_event", rdat[2], 1'h1);
      wclr_ins <= 1'h1;
      @(posedge pclk);
      wclr_ins <= 1'h0;
      repeat (2) @(posedge pclk);
      apb(1'h0, pdwc_pkg::STAT_OFS, 32'h0);
      chk("wdt_clear_ins", rdat[4:3], 2'h3);
      apb(1'h1, pdwc_pkg::IRQ_MASK_OFS, 32'h0);
      @(posedge pclk);
      irq_a = irq;
      apb(1'h1, pdwc_pkg::IRQ_MASK_OFS, 32'h7);
      @(posedge pclk);
      chk("irq_mask", {irq_a, irq}, 2'h1);
      apb(1'h1, pdwc_pkg::IRQ_STAT_OFS, 32'h7);
      apb(1'h0, pdwc_pkg::IRQ_STAT_OFS, 32'h0);
      chk("irq_clear", {irq, rdat[2:0]}, 4'h0);
      tally_and_finish();
   end
endmodule : tb_pdwc_top
